// ==== common/nvsp_pkg.sv ====
// Package with widths, pin timing counts and state codes for the static RAM host port
package nvsp_pkg;
  localparam int NVSP_ADDR_W = 19; // Byte address width
  localparam int NVSP_DATA_W = 8; // Data bus width
  localparam int NVSP_CLK_NS = 50; // Clock period in ns
  // Access pulse time in ns; one clock already exceeds every access grade
  localparam int NVSP_ACC_NS = 50;
  localparam int NVSP_ACC_CYC = (NVSP_ACC_NS + NVSP_CLK_NS - 1) / NVSP_CLK_NS;
  // Hold time of a host-driven store request pulse, in ns
  localparam int NVSP_REQ_NS = 100;
  localparam int NVSP_REQ_CYC = (NVSP_REQ_NS + NVSP_CLK_NS - 1) / NVSP_CLK_NS;
  localparam int NVSP_CNT_W = 4; // Width of the pulse counter
  // Host sequencer states
  typedef enum logic [5:0] {
    NVSP_IDLE = 6'h01,
    NVSP_SETUP = 6'h02,
    NVSP_STROBE = 6'h04,
    NVSP_DONE = 6'h08,
    NVSP_STORE = 6'h10,
    NVSP_WAIT = 6'h20
  } nvsp_state_e;
endpackage : nvsp_pkg

// ==== src/nvsp_pulse_timer.sv ====
// Down counter that times strobe and request pulses
`timescale 1ns/100ps
module nvsp_pulse_timer
  import nvsp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [NVSP_CNT_W-1:0] load_val,
  output logic expired
);
  logic [NVSP_CNT_W-1:0] cnt_q;
  logic [NVSP_CNT_W-1:0] cnt_d;

  // Next count: load wins, else count toward zero
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = load_val;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 4'h1;
    end
  end

  // Count register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign expired = (cnt_q == 4'h0);
endmodule : nvsp_pulse_timer

// ==== src/nvsp_host.sv ====
// Host-side controller that drives the static RAM port pins
`timescale 1ns/100ps
// Functional notes
// - 19-bit address selects one byte
// - One 8-bit bidirectional data bus
// - Device acts only with chip select low
// - Pulling busy line low starts save
// - Software store/recall also possible
module nvsp_host
  import nvsp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [nvsp_pkg::NVSP_ADDR_W-1:0] req_addr,
  input wire logic [nvsp_pkg::NVSP_DATA_W-1:0] req_wdata,
  input wire logic store_req,
  output logic rsp_valid,
  output logic [nvsp_pkg::NVSP_DATA_W-1:0] rsp_rdata,
  output logic dev_busy,
  output logic [nvsp_pkg::NVSP_ADDR_W-1:0] byte_address,
  output logic chip_select_n,
  output logic write_strobe_n,
  output logic output_enable_n,
  input wire logic [nvsp_pkg::NVSP_DATA_W-1:0] data_io_i,
  output logic [nvsp_pkg::NVSP_DATA_W-1:0] data_io_o,
  output logic data_io_oe,
  input wire logic hardware_store_busy_n_i,
  output logic hardware_store_busy_n_o,
  output logic hardware_store_busy_n_oe
);
  import nvsp_pkg::*;

  nvsp_state_e state_q, state_d; // Sequencer state
  logic write_q, write_d; // Current access is a write
  logic [NVSP_ADDR_W-1:0] addr_q, addr_d; // Address pins
  logic [NVSP_DATA_W-1:0] wdata_q, wdata_d; // Write data pins
  logic [NVSP_DATA_W-1:0] rdata_q, rdata_d; // Captured read byte
  logic rsp_q, rsp_d; // Read answer pulse
  logic cs_n_q, cs_n_d; // Chip select pin
  logic we_n_q, we_n_d; // Write strobe pin
  logic oe_n_q, oe_n_d; // Output enable pin
  logic doe_q, doe_d; // Host drives data bus
  logic hsb_oe_q, hsb_oe_d; // Host pulls busy line low
  logic tmr_load; // Start a pulse
  logic [NVSP_CNT_W-1:0] tmr_val; // Pulse length
  logic tmr_done; // Pulse has run out
  logic line_busy; // Busy line seen low

  // Line low marks the device busy, whatever started the save, our own pull included
  assign line_busy = ~hardware_store_busy_n_i;

  nvsp_pulse_timer u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(tmr_load),
    .load_val(tmr_val),
    .expired(tmr_done)
  );

  // Sequencer next state and pin values
  always_comb begin
    state_d = state_q;
    write_d = write_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    rsp_d = 1'b0;
    cs_n_d = cs_n_q;
    we_n_d = we_n_q;
    oe_n_d = oe_n_q;
    doe_d = doe_q;
    hsb_oe_d = hsb_oe_q;
    tmr_load = 1'b0;
    tmr_val = 4'h0;
    unique case (state_q)
      NVSP_IDLE: begin
        // No access starts while the device is busy
        if (line_busy) begin
          state_d = NVSP_IDLE;
        end else if (store_req) begin
          // Open-drain pull low requests a save
          hsb_oe_d = 1'b1;
          tmr_load = 1'b1;
          tmr_val = NVSP_CNT_W'(NVSP_REQ_CYC);
          state_d = NVSP_STORE;
        end else if (req_valid) begin
          // Address settles before chip select falls, since it is latched there
          write_d = req_write;
          addr_d = req_addr;
          wdata_d = req_wdata;
          state_d = NVSP_SETUP;
        end
      end
      NVSP_SETUP: begin
        cs_n_d = 1'b0;
        we_n_d = ~write_q;
        oe_n_d = write_q;
        doe_d = write_q;
        tmr_load = 1'b1;
        tmr_val = NVSP_CNT_W'(NVSP_ACC_CYC);
        state_d = NVSP_STROBE;
      end
      NVSP_STROBE: begin
        if (tmr_done) begin
          // Sample before output enable rises and the bus floats
          if (!write_q) begin
            rdata_d = data_io_i;
            rsp_d = 1'b1;
          end
          cs_n_d = 1'b1;
          we_n_d = 1'b1;
          oe_n_d = 1'b1;
          state_d = NVSP_DONE;
        end
      end
      NVSP_DONE: begin
        // Data held one cycle past strobe release for hold time
        doe_d = 1'b0;
        state_d = NVSP_IDLE;
      end
      NVSP_STORE: begin
        if (tmr_done) begin
          hsb_oe_d = 1'b0;
          state_d = NVSP_WAIT;
        end
      end
      NVSP_WAIT: begin
        // Device ignores pins during the save, so wait out the busy line
        if (!line_busy) begin
          state_d = NVSP_IDLE;
        end
      end
      default: begin
        state_d = NVSP_IDLE;
      end
    endcase
  end

  // Sequencer registers; strobes and chip select idle high, address low, data bus and busy line released at reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= NVSP_IDLE;
      write_q <= 1'b0;
      addr_q <= 19'h00000;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      rsp_q <= 1'b0;
      cs_n_q <= 1'b1;
      we_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      doe_q <= 1'b0;
      hsb_oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      write_q <= write_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      rsp_q <= rsp_d;
      cs_n_q <= cs_n_d;
      we_n_q <= we_n_d;
      oe_n_q <= oe_n_d;
      doe_q <= doe_d;
      hsb_oe_q <= hsb_oe_d;
    end
  end

  // Accept only when idle, device free and no store pending
  assign req_ready = (state_q == NVSP_IDLE) && !line_busy && !store_req;
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;
  assign dev_busy = line_busy;
  assign byte_address = addr_q;
  assign chip_select_n = cs_n_q;
  assign write_strobe_n = we_n_q;
  assign output_enable_n = oe_n_q;
  assign data_io_o = wdata_q;
  assign data_io_oe = doe_q;
  // Open drain: only ever pull low, the pull-up gives the high level
  assign hardware_store_busy_n_o = 1'b0;
  assign hardware_store_busy_n_oe = hsb_oe_q;
endmodule : nvsp_host

// ==== verif/nvsp_host_asserts.sv ====
// Checker of the host port pin sequencing
`timescale 1ns/100ps
module nvsp_host_asserts
  import nvsp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [NVSP_ADDR_W-1:0] byte_address,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic output_enable_n,
  input wire logic data_io_oe,
  input wire logic hardware_store_busy_n_i,
  input wire logic hardware_store_busy_n_o,
  input wire logic hardware_store_busy_n_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Output enable low two cycles, then high
  sequence read_pulse;
    !output_enable_n ##1 !output_enable_n ##1 output_enable_n;
  endsequence
  // Busy line pulled for at least two cycles, then let go one to three cycles later
  sequence store_pulse;
    hardware_store_busy_n_oe[*2] ##[1:3] !hardware_store_busy_n_oe;
  endsequence
  a_strobe_needs_select:
    assert property ((!write_strobe_n || !output_enable_n) |-> !chip_select_n) else $error("strobe");
  a_read_floats_host:
    assert property (!output_enable_n |-> !data_io_oe) else $error("bus clash");
  a_read_answer_time:
    assert property ($fell(output_enable_n) |-> read_pulse ##0 rsp_valid) else $error("read");
  a_store_pulse_len:
    assert property ($rose(hardware_store_busy_n_oe) |-> store_pulse) else $error("store");
  a_busy_blocks_req:
    assert property (!hardware_store_busy_n_i |-> !req_ready) else $error("ready");
  a_no_access_busy:
    assert property ($fell(chip_select_n) |-> hardware_store_busy_n_i) else $error("busy");
  a_write_drives_bus:
    assert property (!write_strobe_n |-> data_io_oe) else $error("write data");
  a_addr_held_select:
    assert property ((!chip_select_n && !$past(chip_select_n)) |-> $stable(byte_address))
      else $error("address moved");
  a_pull_only_low:
    assert property (hardware_store_busy_n_oe |-> !hardware_store_busy_n_o) else $error("pull");
  a_store_no_select:
    assert property (hardware_store_busy_n_oe |-> chip_select_n) else $error("select in store");
endmodule : nvsp_host_asserts
bind nvsp_host nvsp_host_asserts i_nvsp_host_asserts (.clk, .sys_rst, .byte_address, .req_ready,
  .rsp_valid, .chip_select_n, .write_strobe_n, .output_enable_n, .data_io_oe,
  .hardware_store_busy_n_i, .hardware_store_busy_n_o, .hardware_store_busy_n_oe);

// ==== verif/nvsp_dev_model.sv ====
// Device model: byte array and busy line
`timescale 1ns/100ps
module nvsp_dev_model
  import nvsp_pkg::*;
(
  input wire logic clk,
  input wire logic [NVSP_ADDR_W-1:0] byte_address,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic output_enable_n,
  input wire logic [NVSP_DATA_W-1:0] data_io_o,
  input wire logic data_io_oe,
  input wire logic hsb_pull,
  input wire logic boot,
  output logic [NVSP_DATA_W-1:0] data_io_i,
  output logic busy_line
);
  logic [NVSP_DATA_W-1:0] mem [0:(1<<NVSP_ADDR_W)-1]; // Full byte array
  logic [7:0] last_q = 8'h00; // A floating bus shows its inverse
  int save_q = 0; // Save cycles left
  // Boot stands for the power-up reload; a save from any cause shows on the line
  assign busy_line = !(hsb_pull || boot || save_q > 0);
  assign data_io_i = data_io_oe ? data_io_o : (!chip_select_n && !output_enable_n && save_q == 0)
    ? mem[byte_address] : ~last_q;
  // Writes only while selected and not saving
  always @(posedge clk) begin
    last_q <= data_io_i;
    if (hsb_pull) save_q <= 3;
    else if (save_q > 0) save_q <= save_q - 1;
    if (!chip_select_n && !write_strobe_n && save_q == 0) mem[byte_address] <= data_io_i;
  end
endmodule : nvsp_dev_model

// ==== verif/nvsp_host_bench.sv ====
// Self-checking bench of the host port
`timescale 1ns/100ps
module nvsp_host_bench;
  import nvsp_pkg::*;
  logic clk = 0, sys_rst = 1, req_valid = 0, req_write = 0, store_req = 0, boot = 0;
  logic [NVSP_ADDR_W-1:0] req_addr = '0, byte_address;
  logic [NVSP_DATA_W-1:0] req_wdata = '0, rsp_rdata, data_io_i, data_io_o;
  logic req_ready, rsp_valid, dev_busy, chip_select_n, write_strobe_n, output_enable_n;
  logic data_io_oe, hardware_store_busy_n_i, hardware_store_busy_n_o, hardware_store_busy_n_oe;
  int err_count = 0, n_checks = 0, cyc = 0;
  nvsp_host i_nvsp_host (.clk, .sys_rst, .req_valid, .req_ready, .req_write, .req_addr,
    .req_wdata, .store_req, .rsp_valid, .rsp_rdata, .dev_busy, .byte_address, .chip_select_n,
    .write_strobe_n, .output_enable_n, .data_io_i, .data_io_o, .data_io_oe,
    .hardware_store_busy_n_i, .hardware_store_busy_n_o, .hardware_store_busy_n_oe);
  nvsp_dev_model i_nvsp_dev_model (.clk, .byte_address, .chip_select_n, .write_strobe_n,
    .output_enable_n, .data_io_o, .data_io_oe, .boot, .data_io_i,
    .busy_line(hardware_store_busy_n_i),
    .hsb_pull(hardware_store_busy_n_oe && !hardware_store_busy_n_o));
  initial forever #25 clk = ~clk;
  // Ceiling far above the less than one hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      end_sim;
    end
  end
  task automatic chk(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One access; a read must answer four cycles after it is offered with ready high
  task automatic access(input logic wr, input logic [18:0] a, input logic [7:0] wd, exp);
    int n;
    @(negedge clk);
    {req_valid, req_write, req_addr, req_wdata} = {1'b1, wr, a, wd};
    while (!req_ready) @(negedge clk);
    n = 0;
    do begin
      @(negedge clk);
      req_valid = 0;
      n++;
    end while (!wr && !rsp_valid && n < 9);
    if (!wr) chk(rsp_rdata, exp);
    if (!wr) chk(n, 4);
  endtask : access
  task automatic test_rw;
    access(1, 19'h7FFFF, 8'hA5, 8'h00);
    access(1, 19'h00000, 8'h3C, 8'h00);
    access(0, 19'h7FFFF, 8'h00, 8'hA5);
    access(0, 19'h00000, 8'h00, 8'h3C);
    $display("test_rw done");
  endtask : test_rw
  task automatic test_store;
    @(negedge clk);
    store_req = 1;
    @(negedge clk);
    store_req = 0;
    @(negedge clk);
    chk(dev_busy, 1);
    chk(hardware_store_busy_n_oe, 1);
    chk(req_ready, 0);
    access(0, 19'h7FFFF, 8'h00, 8'hA5);
    $display("test_store done");
  endtask : test_store
  task automatic test_boot;
    @(negedge clk);
    boot = 1;
    // A read already waits here, so the host must hold it off
    {req_valid, req_write, req_addr} = {1'b1, 1'b0, 19'h00000};
    repeat (5) @(negedge clk);
    chk(req_ready, 0);
    chk(chip_select_n, 1);
    boot = 0;
    access(0, 19'h00000, 8'h00, 8'h3C);
    $display("test_boot done");
  endtask : test_boot
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (10) @(negedge clk);
    sys_rst = 0;
    test_rw;
    test_store;
    test_boot;
    end_sim;
  end
endmodule : nvsp_host_bench
